// >>> ssc_params.svh
// Constants of the serial status and counter-clear port
// Function
// - Port 5 link state in status word bit 0, one when up.
// - Port 5 speed in bits 2:1, 01 for 100 Mb/s, 00 for 10.
// - Port 5 duplex in bit 3, one for full duplex.
// - Port 5 flow control active in bit 4, zero when disabled.
// - Per-port broken-cable length pair and flag for ports 0 to 4.
// - Receive packet and byte overflow flags at 0x3a, fixed bit positions.
// - Transmit overflow flags at 0x3b, same positions as receive.
// - Collision and error overflow flags at 0x3c, same positions.
// - Read frame: start 01 then opcode 10; only read and clear opcodes are accepted.
// - One table-select bit follows: 1 counters/status, 0 EEPROM.
// - Device drives 32 data bits, bit 31 first, bit 0 last.
// - EEPROM read returns odd word then even word of the pair.
// - Clear frame: same preamble and start, opcode 01.
// - Clear frame carries two-bit device address equal to strap.
// - Reset type 1 clears a whole port, 0 one indexed counter.
// - Clear frame ends with port number or counter index field.
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

`define SSC_PREAMBLE_ONES 6'h20
`define SSC_START_BITS 2'b01
`define SSC_OP_READ 2'b10
`define SSC_OP_CLEAR 2'b01
`define SSC_HDR_LAST 6'h07
`define SSC_TA_LAST 6'h01
`define SSC_DATA_LAST 6'h1f
`define SSC_HDR_TSEL_BIT 7
`define SSC_CLR_DEV_HI 7
`define SSC_CLR_DEV_LO 6
`define SSC_CLR_TYPE_BIT 5
`define SSC_TSEL_COUNTER 1'b1
`define SSC_STRAP_EDGES 3'h6

`define SSC_OFS_PORT5_LINK 7'h02
`define SSC_OFS_CABLE_FAULT 7'h03
`define SSC_OFS_RX_OVF 7'h3a
`define SSC_OFS_TX_OVF 7'h3b
`define SSC_OFS_COL_ERR_OVF 7'h3c
`define SSC_RESET_WORD 32'h0000_0000

`define SSC_MASK_PORT5 32'h0000_001f
`define SSC_MASK_CABLE 32'h00fc_71c7
`define SSC_MASK_OVF 32'h0003_abd5

`define SSC_PUB_P5_LO 0
`define SSC_PUB_CABLE_LO 5
`define SSC_PUB_RX_LO 20
`define SSC_PUB_TX_LO 32
`define SSC_PUB_CE_LO 44

`endif

// >>> ssc_pkg.sv
// Types of the serial status and counter-clear port
package ssc_pkg;
	typedef enum logic [2:0] {
		SSC_PRE = 3'h0,
		SSC_START = 3'h1,
		SSC_OP = 3'h2,
		SSC_HDR = 3'h3,
		SSC_TA = 3'h4,
		SSC_DATA = 3'h5
	} ssc_state_e;
	typedef logic [55:0] ssc_pub_t;
endpackage

// >>> ssc_sync3.sv
// Three-stage synchroniser with agreement filter
module ssc_sync3 #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] lvl_r
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	wire agree = (s2_r == s3_r);

	generate
		if (W < 1) begin : g_bad_w
			$error("ssc_sync3: width must be at least one");
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree) begin
				lvl_r <= s3_r;
			end
		end
	end
endmodule

// >>> ssc_pair_mem.sv
// EEPROM image held as word pairs, written on core clock, read on link clock
module ssc_pair_mem #(
	parameter int AW = 6,
	parameter int DW = 32
) (
	input wire logic wclock,
	input wire logic wen,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic rclock,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_r
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	generate
		if (AW < 1 || DW < 1) begin : g_bad_size
			$error("ssc_pair_mem: address and data widths must be at least one");
		end
	endgenerate

	// Contents are loaded once at start; reads and writes never overlap in use
	always_ff @(posedge wclock) begin
		if (wen) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge rclock) begin
		rdata_r <= mem[raddr];
	end
endmodule

// >>> ssc_port.sv
// Serial read and counter-clear port with status registers
`include "ssc_params.svh"
module ssc_port #(
	parameter int CLR_IDX_W = 5
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic serial_clock_pin,
	input wire logic serial_select_pin,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	input wire logic [1:0] strapped_chip_address,
	input wire logic port5_link_up,
	input wire logic [1:0] port5_speed,
	input wire logic port5_full_duplex,
	input wire logic port5_flow_ctrl,
	input wire logic [9:0] cable_len,
	input wire logic [4:0] cable_broken,
	input wire logic [5:0] rx_pkt_ovf,
	input wire logic [5:0] rx_byte_ovf,
	input wire logic [5:0] tx_pkt_ovf,
	input wire logic [5:0] tx_byte_ovf,
	input wire logic [5:0] col_ovf,
	input wire logic [5:0] err_ovf,
	input wire logic ee_wr_en,
	input wire logic [5:0] ee_wr_addr,
	input wire logic [31:0] ee_wr_data,
	output logic clear_valid,
	output logic clear_whole_port,
	output logic [CLR_IDX_W-1:0] clear_target
);
	generate
		if (CLR_IDX_W != 5) begin : g_bad_width
			$error("ssc_port: clear field must fill the 8-bit header");
		end
	endgenerate

	function automatic logic [31:0] ssc_scatter(input logic [31:0] mask, input logic [35:0] bits);
		logic [31:0] w;
		int k;
		w = '0;
		k = 0;
		for (int i = 0; i < 32; i++) begin
			if (mask[i]) begin
				w[i] = bits[k];
				k++;
			end
		end
		return w;
	endfunction

	// Core domain: status capture and publication
	logic [4:0] p5_r;
	logic [14:0] cable_r;
	logic [11:0] rx_ovf_r;
	logic [11:0] tx_ovf_r;
	logic [11:0] ce_ovf_r;
	ssc_pkg::ssc_pub_t pub_r;
	logic pub_req_r;
	logic ack_lvl;
	logic taken_r;
	wire ssc_pkg::ssc_pub_t pub_nxt = {ce_ovf_r, tx_ovf_r, rx_ovf_r, cable_r, p5_r};
	wire pub_idle = (pub_req_r == ack_lvl);
	wire [14:0] cable_pack = {cable_broken[4], cable_len[9:8], cable_broken[3], cable_len[7:6],
		cable_broken[2], cable_len[5:4], cable_broken[1], cable_len[3:2],
		cable_broken[0], cable_len[1:0]};

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			p5_r <= 5'h00;
			cable_r <= 15'h0000;
			rx_ovf_r <= 12'h000;
			tx_ovf_r <= 12'h000;
			ce_ovf_r <= 12'h000;
		end else begin
			p5_r <= {port5_flow_ctrl, port5_full_duplex, port5_speed, port5_link_up};
			cable_r <= cable_pack;
			rx_ovf_r <= {rx_byte_ovf, rx_pkt_ovf};
			tx_ovf_r <= {tx_byte_ovf, tx_pkt_ovf};
			ce_ovf_r <= {err_ovf, col_ovf};
		end
	end

	// Snapshot held still until the link side has taken it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pub_r <= '0;
			pub_req_r <= 1'b0;
		end else if (pub_idle) begin
			pub_r <= pub_nxt;
			pub_req_r <= ~pub_req_r;
		end
	end

	ssc_sync3 #(.W(1)) u_ack_sync (
		.clock(clock),
		.rst_b(rst_b),
		.d(taken_r),
		.lvl_r(ack_lvl)
	);

	// Strap caught once after reset; window outlasts synchroniser fill
	logic [1:0] strap_lvl;
	logic [1:0] strap_r;
	logic [2:0] strap_cnt_r;
	ssc_sync3 #(.W(2)) u_strap_sync (
		.clock(clock),
		.rst_b(rst_b),
		.d(strapped_chip_address),
		.lvl_r(strap_lvl)
	);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			strap_r <= 2'h0;
			strap_cnt_r <= 3'h0;
		end else if (strap_cnt_r != `SSC_STRAP_EDGES) begin
			strap_cnt_r <= strap_cnt_r + 3'h1;
			strap_r <= strap_lvl;
		end
	end

	// Link domain
	ssc_pkg::ssc_state_e state_r, state_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [1:0] op_r;
	logic [6:0] hdr_r;
	logic rd_tsel_r;
	logic [6:0] rd_addr_r;
	logic [31:0] word_r;
	logic [7:0] clr_hdr_r;
	logic clr_tog_r;
	ssc_pkg::ssc_pub_t copy_r;
	logic req_lvl;
	logic [31:0] mem_q;
	logic dout_r;
	logic oe_r;

	wire din = serial_data_pin_in;
	wire pre_full = (cnt_r == `SSC_PREAMBLE_ONES);
	wire [1:0] op_in = {op_r[0], din};
	wire op_ok = (op_in == `SSC_OP_READ) || (op_in == `SSC_OP_CLEAR);
	wire [7:0] hdr_in = {hdr_r, din};
	wire hdr_last = (state_r == ssc_pkg::SSC_HDR) && (cnt_r == `SSC_HDR_LAST);
	wire is_read = (op_r == `SSC_OP_READ);
	wire ta_last = (state_r == ssc_pkg::SSC_TA) && (cnt_r == `SSC_TA_LAST);
	wire data_last = (state_r == ssc_pkg::SSC_DATA) && (cnt_r == `SSC_DATA_LAST);

	// Status word per address; unlisted counter addresses read zero
	// field scatter
	wire [31:0] w_p5 = ssc_scatter(`SSC_MASK_PORT5, {31'h0, copy_r[4:0]});
	wire [31:0] w_cable = ssc_scatter(`SSC_MASK_CABLE, {21'h0, copy_r[19:5]});
	wire [31:0] w_rx = ssc_scatter(`SSC_MASK_OVF, {24'h0, copy_r[31:20]});
	wire [31:0] w_tx = ssc_scatter(`SSC_MASK_OVF, {24'h0, copy_r[43:32]});
	wire [31:0] w_ce = ssc_scatter(`SSC_MASK_OVF, {24'h0, copy_r[55:44]});
	wire [31:0] status_word =
		(rd_addr_r == `SSC_OFS_PORT5_LINK) ? w_p5 :
		(rd_addr_r == `SSC_OFS_CABLE_FAULT) ? w_cable :
		(rd_addr_r == `SSC_OFS_RX_OVF) ? w_rx :
		(rd_addr_r == `SSC_OFS_TX_OVF) ? w_tx :
		(rd_addr_r == `SSC_OFS_COL_ERR_OVF) ? w_ce : `SSC_RESET_WORD;

	// Frame sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 6'h01;
		if (serial_select_pin) begin
			state_nxt = ssc_pkg::SSC_PRE;
			cnt_nxt = 6'h00;
		end else begin
			unique case (state_r)
				ssc_pkg::SSC_PRE: begin
					if (din) begin
						cnt_nxt = pre_full ? cnt_r : cnt_r + 6'h01;
					end else begin
						cnt_nxt = 6'h00;
						if (pre_full) begin
							state_nxt = ssc_pkg::SSC_START;
						end
					end
				end
				ssc_pkg::SSC_START: begin
					cnt_nxt = 6'h00;
					state_nxt = din ? ssc_pkg::SSC_OP : ssc_pkg::SSC_PRE;
				end
				ssc_pkg::SSC_OP: begin
					if (cnt_r == 6'h01) begin
						cnt_nxt = 6'h00;
						state_nxt = op_ok ? ssc_pkg::SSC_HDR : ssc_pkg::SSC_PRE;
					end
				end
				ssc_pkg::SSC_HDR: begin
					if (hdr_last) begin
						cnt_nxt = 6'h00;
						state_nxt = is_read ? ssc_pkg::SSC_TA : ssc_pkg::SSC_PRE;
					end
				end
				ssc_pkg::SSC_TA: begin
					if (ta_last) begin
						cnt_nxt = 6'h00;
						state_nxt = ssc_pkg::SSC_DATA;
					end
				end
				ssc_pkg::SSC_DATA: begin
					if (data_last) begin
						cnt_nxt = 6'h00;
						state_nxt = ssc_pkg::SSC_PRE;
					end
				end
				default: begin
					cnt_nxt = 6'h00;
					state_nxt = ssc_pkg::SSC_PRE;
				end
			endcase
		end
	end

	always_ff @(posedge serial_clock_pin or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ssc_pkg::SSC_PRE;
			cnt_r <= 6'h00;
			op_r <= 2'h0;
			hdr_r <= 7'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			op_r <= (state_r == ssc_pkg::SSC_OP) ? op_in : op_r;
			hdr_r <= (state_r == ssc_pkg::SSC_HDR) ? hdr_in[6:0] : hdr_r;
		end
	end

	always_ff @(posedge serial_clock_pin or negedge rst_b) begin
		if (!rst_b) begin
			rd_tsel_r <= 1'b0;
			rd_addr_r <= 7'h00;
			clr_hdr_r <= 8'h00;
			clr_tog_r <= 1'b0;
		end else if (hdr_last && is_read) begin
			rd_tsel_r <= hdr_in[`SSC_HDR_TSEL_BIT];
			rd_addr_r <= hdr_in[6:0];
		end else if (hdr_last) begin
			clr_hdr_r <= hdr_in;
			clr_tog_r <= ~clr_tog_r;
		end
	end

	// pair entry already holds odd word high, even word low
	ssc_pair_mem #(.AW(6), .DW(32)) u_mem (
		.wclock(clock),
		.wen(ee_wr_en),
		.waddr(ee_wr_addr),
		.wdata(ee_wr_data),
		.rclock(serial_clock_pin),
		.raddr(rd_addr_r[6:1]),
		.rdata_r(mem_q)
	);

	// Word chosen at end of turnaround
	always_ff @(posedge serial_clock_pin or negedge rst_b) begin
		if (!rst_b) begin
			word_r <= `SSC_RESET_WORD;
		end else if (ta_last) begin
			word_r <= (rd_tsel_r == `SSC_TSEL_COUNTER) ? status_word : mem_q;
		end
	end

	// Snapshot taken over by link side; preamble supplies the edges
	ssc_sync3 #(.W(1)) u_req_sync (
		.clock(serial_clock_pin),
		.rst_b(rst_b),
		.d(pub_req_r),
		.lvl_r(req_lvl)
	);
	always_ff @(posedge serial_clock_pin or negedge rst_b) begin
		if (!rst_b) begin
			copy_r <= '0;
			taken_r <= 1'b0;
		end else if (req_lvl != taken_r) begin
			copy_r <= pub_r;
			taken_r <= req_lvl;
		end
	end

	// msb first, driven on falling edge
	always_ff @(negedge serial_clock_pin or negedge rst_b) begin
		if (!rst_b) begin
			oe_r <= 1'b0;
			dout_r <= 1'b0;
		end else begin
			oe_r <= (state_r == ssc_pkg::SSC_DATA);
			dout_r <= (state_r == ssc_pkg::SSC_DATA) ? word_r[~cnt_r[4:0]] : 1'b0;
		end
	end
	assign serial_data_pin_out = dout_r;
	assign serial_data_pin_oe = oe_r;

	// Core side of counter clear
	logic clr_lvl;
	logic clr_seen_r;
	logic clr_valid_r;
	logic clr_port_r;
	logic [CLR_IDX_W-1:0] clr_target_r;
	ssc_sync3 #(.W(1)) u_clr_sync (
		.clock(clock),
		.rst_b(rst_b),
		.d(clr_tog_r),
		.lvl_r(clr_lvl)
	);
	wire clr_new = (clr_lvl != clr_seen_r);
	wire dev_match = (clr_hdr_r[`SSC_CLR_DEV_HI:`SSC_CLR_DEV_LO] == strap_r);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clr_seen_r <= 1'b0;
			clr_valid_r <= 1'b0;
			clr_port_r <= 1'b0;
			clr_target_r <= '0;
		end else begin
			clr_seen_r <= clr_lvl;
			clr_valid_r <= clr_new && dev_match;
			if (clr_new && dev_match) begin
				clr_port_r <= clr_hdr_r[`SSC_CLR_TYPE_BIT];
				clr_target_r <= clr_hdr_r[CLR_IDX_W-1:0];
			end
		end
	end
	assign clear_valid = clr_valid_r;
	assign clear_whole_port = clr_port_r;
	assign clear_target = clr_target_r;

	wire rd_02 = ta_last && rd_tsel_r && (rd_addr_r == `SSC_OFS_PORT5_LINK);
	wire rd_03 = ta_last && rd_tsel_r && (rd_addr_r == `SSC_OFS_CABLE_FAULT);
	wire rd_3a = ta_last && rd_tsel_r && (rd_addr_r == `SSC_OFS_RX_OVF);
	wire rd_3b = ta_last && rd_tsel_r && (rd_addr_r == `SSC_OFS_TX_OVF);
	wire rd_3c = ta_last && rd_tsel_r && (rd_addr_r == `SSC_OFS_COL_ERR_OVF);

	property p_port5_word;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		rd_02 |=> word_r == {27'h0, $past(copy_r[4:0])};
	endproperty
	a_port5_word: assert property (p_port5_word) else $error("port 5 word wrong");

	property p_cable_word;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		rd_03 |=> word_r[2:0] == $past(copy_r[7:5]) && word_r[23:21] == $past(copy_r[19:17])
			&& word_r[5:3] == 3'h0;
	endproperty
	a_cable_word: assert property (p_cable_word) else $error("cable word wrong");

	property p_rx_word;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		rd_3a |=> word_r[0] == $past(copy_r[20]) && word_r[17] == $past(copy_r[31]) && !word_r[1];
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("rx overflow word wrong");

	property p_tx_word;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		rd_3b |=> word_r[9] == $past(copy_r[38]) && word_r[8] == $past(copy_r[37]);
	endproperty
	a_tx_word: assert property (p_tx_word) else $error("tx overflow word wrong");

	property p_ce_word;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		rd_3c |=> word_r[8] == $past(copy_r[49]) && word_r[9] == $past(copy_r[50]);
	endproperty
	a_ce_word: assert property (p_ce_word) else $error("collision word wrong");

	property p_ee_word;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		(ta_last && !rd_tsel_r) |=> word_r == $past(mem_q);
	endproperty
	a_ee_word: assert property (p_ee_word) else $error("eeprom pair wrong");

	sequence s_first_bits;
		serial_data_pin_out == word_r[31] ##1 serial_data_pin_out == word_r[30];
	endsequence
	property p_msb_first;
		@(negedge serial_clock_pin) disable iff (!rst_b)
		$rose(serial_data_pin_oe) |-> s_first_bits and serial_data_pin_oe [*8];
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("data not msb first");

	property p_bad_op;
		@(posedge serial_clock_pin) disable iff (!rst_b)
		(state_r == ssc_pkg::SSC_OP && cnt_r == 6'h01 && !op_ok && !serial_select_pin)
			|=> state_r == ssc_pkg::SSC_PRE;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("bad opcode accepted");

	property p_clear_match;
		@(posedge clock) disable iff (!rst_b)
		clear_valid |-> clr_hdr_r[`SSC_CLR_DEV_HI:`SSC_CLR_DEV_LO] == strap_r
			&& clear_whole_port == clr_hdr_r[`SSC_CLR_TYPE_BIT];
	endproperty
	a_clear_match: assert property (p_clear_match) else $error("clear for other device");
endmodule

// >>> ssc_ctrl_model.sv
// Management controller model that drives the serial link frames
module ssc_ctrl_model (
	output logic serial_clock_pin,
	output logic serial_select_pin,
	output logic ctrl_data,
	output logic ctrl_en,
	input wire logic data_wire,
	input wire logic dev_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 80;
	logic oe_bad;
	initial begin
		serial_clock_pin = 1'b0;
		serial_select_pin = 1'b0;
		ctrl_data = 1'b1;
		ctrl_en = 1'b1;
		oe_bad = 1'b0;
	end
	task automatic bit_out(input logic b);
		ctrl_data <= b;
		#HALF serial_clock_pin <= 1'b1;
		#HALF serial_clock_pin <= 1'b0;
	endtask
	task automatic header(input logic [1:0] op, input logic [7:0] hdr);
		repeat (32) bit_out(1'b1);
		bit_out(1'b0);
		bit_out(1'b1);
		for (int i = 1; i >= 0; i--) bit_out(op[i]);
		for (int i = 7; i >= 0; i--) bit_out(hdr[i]);
	endtask
	task automatic idle();
		ctrl_en <= 1'b1;
		repeat (2) bit_out(1'b1);
	endtask
	// Refused opcodes expect nobody on the line, so the pull-up reads ones
	task automatic read_word(input logic [1:0] op, input logic tsel, input logic [6:0] addr,
			output logic [31:0] d);
		logic drive;
		drive = (op == 2'b10);
		oe_bad = 1'b0;
		header(op, {tsel, addr});
		ctrl_en <= 1'b0;
		bit_out(1'b1);
		#HALF serial_clock_pin <= 1'b1;
		if (dev_oe !== 1'b0) oe_bad = 1'b1;
		#HALF serial_clock_pin <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			#HALF serial_clock_pin <= 1'b1;
			d[i] = data_wire;
			if (dev_oe !== drive) oe_bad = 1'b1;
			#HALF serial_clock_pin <= 1'b0;
		end
		#HALF;
		if (dev_oe !== 1'b0) oe_bad = 1'b1;
		idle();
	endtask
	task automatic clear_frame(input logic [1:0] dev, input logic whole, input logic [4:0] idx);
		header(2'b01, {dev, whole, idx});
		idle();
	endtask
	// Select raised after the opcode; the device must drop the frame
	task automatic cut_clear(input logic [1:0] dev, input logic [4:0] idx);
		logic [7:0] hdr;
		hdr = {dev, 1'b1, idx};
		repeat (32) bit_out(1'b1);
		bit_out(1'b0);
		bit_out(1'b1);
		bit_out(1'b0);
		bit_out(1'b1);
		serial_select_pin <= 1'b1;
		for (int i = 7; i >= 0; i--) bit_out(hdr[i]);
		serial_select_pin <= 1'b0;
		idle();
	endtask
endmodule

// >>> tb_top.sv
// Self-checking bench of the serial status and counter-clear port
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic serial_clock_pin, serial_select_pin, ctrl_data, ctrl_en, data_wire;
	logic serial_data_pin_out, serial_data_pin_oe;
	logic [1:0] strap = 2'b10;
	logic [55:0] st = '0;
	logic ee_wr_en = 1'b0;
	logic [5:0] ee_wr_addr = '0;
	logic [31:0] ee_wr_data = '0;
	logic clear_valid, clear_whole_port;
	logic [4:0] clear_target;
	int n_fail = 0;
	int cmp_count = 0;
	int n_clr = 0;
	int cyc = 0;
	always #50 clock = ~clock;
	// Pull-up when neither side drives
	assign data_wire = serial_data_pin_oe ? serial_data_pin_out : (ctrl_en ? ctrl_data : 1'b1);
	ssc_port u_ssc_port (.clock(clock), .rst_b(rst_b), .serial_clock_pin(serial_clock_pin),
		.serial_select_pin(serial_select_pin), .serial_data_pin_in(data_wire),
		.serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
		.strapped_chip_address(strap), .port5_link_up(st[0]), .port5_speed(st[2:1]),
		.port5_full_duplex(st[3]), .port5_flow_ctrl(st[4]), .cable_len(st[14:5]),
		.cable_broken(st[19:15]), .rx_pkt_ovf(st[25:20]), .rx_byte_ovf(st[31:26]),
		.tx_pkt_ovf(st[37:32]), .tx_byte_ovf(st[43:38]), .col_ovf(st[49:44]),
		.err_ovf(st[55:50]), .ee_wr_en(ee_wr_en), .ee_wr_addr(ee_wr_addr),
		.ee_wr_data(ee_wr_data), .clear_valid(clear_valid),
		.clear_whole_port(clear_whole_port), .clear_target(clear_target));
	ssc_ctrl_model u_ssc_ctrl_model (.serial_clock_pin(serial_clock_pin),
		.serial_select_pin(serial_select_pin), .ctrl_data(ctrl_data), .ctrl_en(ctrl_en),
		.data_wire(data_wire), .dev_oe(serial_data_pin_oe));
	always @(posedge clock) begin
		if (clear_valid === 1'b1) n_clr++;
		cyc++;
		// Whole run needs well under this
		if (cyc == 30000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] ovf_word(input logic [5:0] a, input logic [5:0] b);
		int pos[6] = '{0, 2, 4, 6, 7, 8};
		logic [31:0] w = '0;
		for (int i = 0; i < 6; i++) begin
			w[pos[i]] = a[i];
			w[pos[i] + 9] = b[i];
		end
		return w;
	endfunction
	function automatic logic [31:0] cable_word(input logic [9:0] len, input logic [4:0] brk);
		int base[5] = '{0, 6, 12, 18, 21};
		logic [31:0] w = '0;
		for (int i = 0; i < 5; i++) begin
			w[base[i] +: 2] = len[2*i +: 2];
			w[base[i] + 2] = brk[i];
		end
		return w;
	endfunction
	task automatic test_status(input logic [55:0] v);
		logic [6:0] ad[6] = '{7'h02, 7'h03, 7'h3a, 7'h3b, 7'h3c, 7'h10};
		logic [31:0] ex[6];
		logic [31:0] d;
		@(posedge clock);
		st <= {v[55:3], 1'b0, v[1:0]};
		repeat (10) @(posedge clock);
		ex[0] = {27'h0, st[4:0]};
		ex[1] = cable_word(st[14:5], st[19:15]);
		ex[2] = ovf_word(st[25:20], st[31:26]);
		ex[3] = ovf_word(st[37:32], st[43:38]);
		ex[4] = ovf_word(st[49:44], st[55:50]);
		ex[5] = '0;
		for (int i = 0; i < 6; i++) begin
			u_ssc_ctrl_model.read_word(2'b10, 1'b1, ad[i], d);
			check("status word", ex[i], d);
			check("drive window", 32'h0, {31'h0, u_ssc_ctrl_model.oe_bad});
		end
	endtask
	task automatic test_eeprom();
		logic [31:0] d;
		for (int i = 2; i < 4; i++) begin
			@(posedge clock);
			ee_wr_en <= 1'b1;
			ee_wr_addr <= 6'(i);
			ee_wr_data <= {16'hbe00 + 16'(i), 16'h1200 + 16'(i)};
		end
		@(posedge clock);
		ee_wr_en <= 1'b0;
		repeat (4) @(posedge clock);
		for (int a = 4; a < 8; a++) begin
			u_ssc_ctrl_model.read_word(2'b10, 1'b0, 7'(a), d);
			check("eeprom pair", {16'hbe00 + 16'(a / 2), 16'h1200 + 16'(a / 2)}, d);
		end
	endtask
	task automatic test_clear();
		logic [1:0] dv[3] = '{2'b10, 2'b10, 2'b01};
		logic [4:0] ix[3] = '{5'h03, 5'h1b, 5'h04};
		logic [1:0] ok[3] = '{2'b11, 2'b10, 2'b00};
		logic [5:0] exp_f;
		int n0;
		for (int i = 0; i < 3; i++) begin
			n0 = n_clr;
			if (ok[i][1]) exp_f = {ok[i][0], ix[i]};
			u_ssc_ctrl_model.clear_frame(dv[i], ok[i][0] | ~ok[i][1], ix[i]);
			repeat (10) @(posedge clock);
			check("clear pulses", {31'h0, ok[i][1]}, 32'(n_clr - n0));
			check("clear fields", {26'h0, exp_f}, {26'h0, clear_whole_port, clear_target});
		end
		n0 = n_clr;
		u_ssc_ctrl_model.cut_clear(2'b10, 5'h02);
		repeat (10) @(posedge clock);
		check("cut clear pulses", 32'h0, 32'(n_clr - n0));
		check("cut clear fields", {26'h0, exp_f}, {26'h0, clear_whole_port, clear_target});
	endtask
	task automatic test_refused();
		logic [1:0] ops[2] = '{2'b00, 2'b11};
		logic [31:0] d;
		int n0;
		for (int i = 0; i < 2; i++) begin
			n0 = n_clr;
			u_ssc_ctrl_model.read_word(ops[i], 1'b1, 7'h02, d);
			repeat (10) @(posedge clock);
			check("refused line", 32'hffff_ffff, d);
			check("refused drive", 32'h0, {31'h0, u_ssc_ctrl_model.oe_bad});
			check("refused clear", 32'h0, 32'(n_clr - n0));
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		check("outputs in reset", 32'h0, {29'h0, clear_valid, serial_data_pin_oe,
			serial_data_pin_out});
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (8) @(posedge clock);
		test_status(56'h0);
		test_status(56'ha5_3c96_0ff0_e1d3);
		test_status(56'h5a_c369_f00f_1e2b);
		test_eeprom();
		test_clear();
		test_refused();
		test_done();
	end
endmodule
